// ---- rtl/dll_daa_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module dll_daa_regs
    import dll_pkg::*;
#(
    parameter int CYC_512 = FOH_MS_00 * CYC_PER_MS,
    parameter int CYC_128 = FOH_MS_01 * CYC_PER_MS,
    parameter int CYC_64  = FOH_MS_10 * CYC_PER_MS,
    parameter int CYC_8   = FOH_MS_11 * CYC_PER_MS,
    parameter int LVS_W   = 8
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    // avalon-mm slave
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    // controller line-state request
    input  wire logic             ctrl_line_valid,
    input  wire logic [1:0]       ctrl_line_state,
    // line-side inputs (asynchronous)
    input  wire logic             billing_tone_in,
    input  wire logic             frame_lock_in,
    input  wire logic             line_low_in,
    input  wire logic             line_zero_in,
    input  wire logic [LVS_W-1:0] line_voltage_raw,
    // line-side controls
    output logic [1:0]            line_state_select,
    output logic                  offhook_busy,
    output logic                  offhook_done,
    output logic                  device_powerdown,
    output logic                  line_side_powerdown,
    output logic                  hybrid_tx_connect,
    output logic [1:0]            analog_out_rx_gain,
    output logic [1:0]            analog_out_tx_gain,
    output logic                  analog_rx_mute,
    output logic                  analog_tx_mute,
    output logic [LVS_W-1:0]      line_voltage_status
);
    if (LVS_W < 1 || LVS_W > 32) begin : g_bad_width
        $error("LVS_W must be 1 to 32");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [LVS_W+3:0] sync1_ff;
    logic [LVS_W+3:0] sync2_ff;
    logic             bt_s;
    logic             fl_s;
    logic             low_s;
    logic             zero_s;
    logic [LVS_W-1:0] lv_s;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {billing_tone_in, frame_lock_in, line_low_in,
                         line_zero_in, line_voltage_raw};
            sync2_ff <= sync1_ff;
        end
    end

    assign bt_s   = sync2_ff[LVS_W+3];
    assign fl_s   = sync2_ff[LVS_W+2];
    assign low_s  = sync2_ff[LVS_W+1];
    assign zero_s = sync2_ff[LVS_W];
    assign lv_s   = sync2_ff[LVS_W-1:0];

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic wr_off;
    logic wr_pwr;
    logic wr_gain;
    logic rd_stat;
    logic acc_ff;

    // one wait cycle: answer in the second cycle of each request
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            acc_ff <= 1'b0;
        else if (acc_ff)
            acc_ff <= 1'b0;
        else
            acc_ff <= avs_read | avs_write;
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~acc_ff;

    always_comb begin
        wr_off  = 1'b0;
        wr_pwr  = 1'b0;
        wr_gain = 1'b0;
        if (avs_write && acc_ff && avs_byteenable[0]) begin
            if (avs_address == ADDR_OFFHOOK)
                wr_off = 1'b1;
            else if (avs_address == ADDR_POWER_PATH)
                wr_pwr = 1'b1;
            else if (avs_address == ADDR_GAIN)
                wr_gain = 1'b1;
        end
    end

    // clear on the edge that captures read data, so no new set is lost
    assign rd_stat = avs_read && !acc_ff && (avs_address == ADDR_LINK_STAT);

    // ------------------------------------------------------------
    // off-hook / line mode register
    // ------------------------------------------------------------
    logic [7:0] offhook_ff;
    logic [1:0] nxt_lm;

    always_comb begin
        nxt_lm = offhook_ff[LM_LSB +: 2];
        if (wr_off && avs_writedata[LM_LSB +: 2] != DLL_RSVD)
            nxt_lm = avs_writedata[LM_LSB +: 2];
        else if (ctrl_line_valid && ctrl_line_state != DLL_RSVD)
            nxt_lm = ctrl_line_state;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            offhook_ff <= RST_OFFHOOK;
        end else begin
            if (wr_off)
                offhook_ff[FOH_LSB +: 2] <= avs_writedata[FOH_LSB +: 2];
            offhook_ff[LM_LSB +: 2] <= nxt_lm;
        end
    end

    assign line_state_select = offhook_ff[LM_LSB +: 2];

    // ------------------------------------------------------------
    // power and path register
    // ------------------------------------------------------------
    logic [7:0] pwr_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            pwr_ff <= RST_POWER_PATH;
        else if (wr_pwr)
            pwr_ff <= avs_writedata[7:0];
    end

    assign device_powerdown    = pwr_ff[PDN_BIT];
    assign line_side_powerdown = pwr_ff[PDL_BIT];
    assign hybrid_tx_connect   = pwr_ff[HBE_BIT];

    // ------------------------------------------------------------
    // billing tone and frame status
    // ------------------------------------------------------------
    logic btd_ff;
    logic fdt_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            btd_ff <= 1'b0;
        else if (pwr_ff[BTE_BIT] && bt_s)
            btd_ff <= 1'b1;
        else if (rd_stat || !pwr_ff[BTE_BIT])
            btd_ff <= 1'b0;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            fdt_ff <= 1'b0;
        else
            fdt_ff <= fl_s;
    end

    // ------------------------------------------------------------
    // line voltage status
    // ------------------------------------------------------------
    logic [LVS_W-1:0] lvs_ff;
    logic [LVS_W-1:0] lv_prev_ff;

    // word is synced bit by bit: take it only once two samples agree
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            lv_prev_ff <= '0;
        else
            lv_prev_ff <= lv_s;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            lvs_ff <= '0;
        else if (zero_s)
            lvs_ff <= '0;
        else if (!pwr_ff[LINE_VOLTAGE_FORCE_DISABLE_BIT] && low_s)
            lvs_ff <= '0;
        else if (lv_s == lv_prev_ff)
            lvs_ff <= lv_s;
    end

    assign line_voltage_status = lvs_ff;

    // ------------------------------------------------------------
    // analog output gain register
    // ------------------------------------------------------------
    logic [7:0] gain_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            gain_ff <= RST_GAIN;
        else if (wr_gain)
            gain_ff <= avs_writedata[7:0] & MASK_GAIN;
    end

    assign analog_out_rx_gain = gain_ff[ARL_LSB +: 2];
    assign analog_out_tx_gain = gain_ff[ATL_LSB +: 2];
    assign analog_rx_mute     = (gain_ff[ARL_LSB +: 2] == 2'h3);
    assign analog_tx_mute     = (gain_ff[ATL_LSB +: 2] == 2'h3);

    // ------------------------------------------------------------
    // off-hook counter
    // ------------------------------------------------------------
    logic start_oh;

    assign start_oh = (nxt_lm == DLL_OFF_HOOK) &&
                      (line_state_select != DLL_OFF_HOOK);

    dll_offhook_timer #(
        .CYC_512 (CYC_512),
        .CYC_128 (CYC_128),
        .CYC_64  (CYC_64),
        .CYC_8   (CYC_8)
    ) u_timer (
        .mclk  (mclk),
        .nrst  (nrst),
        .start (start_oh),
        .abort (line_state_select != DLL_OFF_HOOK && !start_oh),
        .sel   (offhook_ff[FOH_LSB +: 2]),
        .busy  (offhook_busy),
        .done  (offhook_done)
    );

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (avs_address == ADDR_OFFHOOK)
            rd_byte = offhook_ff & MASK_OFFHOOK;
        else if (avs_address == ADDR_POWER_PATH)
            rd_byte = pwr_ff;
        else if (avs_address == ADDR_LINK_STAT) begin
            rd_byte[FDT_BIT] = fdt_ff;
            rd_byte[BTD_BIT] = btd_ff;
        end else if (avs_address == ADDR_GAIN)
            rd_byte = gain_ff;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            avs_readdata <= 32'h00000000;
        else if (avs_read && !acc_ff)
            avs_readdata <= {24'h000000, rd_byte};
    end
endmodule : dll_daa_regs
`default_nettype wire

// ---- rtl/dll_pkg.sv ----
`default_nettype none
package dll_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_OFFHOOK    = 4'h0;
    localparam logic [3:0] ADDR_POWER_PATH = 4'h4;
    localparam logic [3:0] ADDR_LINK_STAT  = 4'h8;
    localparam logic [3:0] ADDR_GAIN       = 4'hc;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FOH_LSB  = 6;
    localparam int LM_LSB   = 0;
    localparam int BTE_BIT  = 7;
    localparam int PDN_BIT  = 6;
    localparam int PDL_BIT  = 5;
    localparam int LINE_VOLTAGE_FORCE_DISABLE_BIT = 4;
    localparam int HBE_BIT  = 2;
    localparam int FDT_BIT  = 3;
    localparam int BTD_BIT  = 0;
    localparam int ARL_LSB  = 2;
    localparam int ATL_LSB  = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OFFHOOK    = 8'h40;
    localparam logic [7:0] RST_POWER_PATH = 8'h00;
    localparam logic [7:0] RST_GAIN       = 8'h0f;
    // writable masks (reserved "do not modify" bits are not stored and read as zero)
    localparam logic [7:0] MASK_OFFHOOK   = 8'hc3;
    localparam logic [7:0] MASK_GAIN      = 8'h0f;

    // ------------------------------------------------------------
    // off-hook counter lengths
    // ------------------------------------------------------------
    localparam int  MCLK_HZ     = 25_000_000;
    localparam int  FOH_MS_00   = 512;
    localparam int  FOH_MS_01   = 128;
    localparam int  FOH_MS_10   = 64;
    localparam int  FOH_MS_11   = 8;
    localparam int  CYC_PER_MS  = MCLK_HZ / 1000;

    typedef enum logic [1:0] {
        DLL_ON_HOOK  = 2'h0,
        DLL_OFF_HOOK = 2'h1,
        DLL_MONITOR  = 2'h2,
        DLL_RSVD     = 2'h3
    } dll_line_t;

    typedef enum logic [2:0] {
        DLL_ST_IDLE   = 3'b001,
        DLL_ST_COUNT  = 3'b010,
        DLL_ST_DONE   = 3'b100
    } dll_hook_st_t;
endpackage : dll_pkg
`default_nettype wire

// ---- rtl/dll_offhook_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module dll_offhook_timer
    import dll_pkg::*;
#(
    parameter int CYC_512 = FOH_MS_00 * CYC_PER_MS,
    parameter int CYC_128 = FOH_MS_01 * CYC_PER_MS,
    parameter int CYC_64  = FOH_MS_10 * CYC_PER_MS,
    parameter int CYC_8   = FOH_MS_11 * CYC_PER_MS
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [1:0] sel,
    output logic            busy,
    output logic            done
);
    // counts must fit the 24-bit down-counter
    if (CYC_8 < 1 || CYC_64 < 1 || CYC_128 < 1 || CYC_512 < 1 ||
        CYC_8 > 16777216 || CYC_64 > 16777216 ||
        CYC_128 > 16777216 || CYC_512 > 16777216) begin : g_bad_counts
        $error("off-hook counts must be 1 to 16777216");
    end

    dll_hook_st_t st_ff;
    logic [23:0]  cnt_ff;
    logic [23:0]  load;

    always_comb begin
        case (sel)
            2'h0:    load = 24'(CYC_512);
            2'h1:    load = 24'(CYC_128);
            2'h2:    load = 24'(CYC_64);
            default: load = 24'(CYC_8);
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff  <= DLL_ST_IDLE;
            cnt_ff <= 24'h000000;
        end else if (abort) begin
            st_ff  <= DLL_ST_IDLE;
            cnt_ff <= 24'h000000;
        end else begin
            case (st_ff)
                DLL_ST_IDLE: begin
                    if (start) begin
                        st_ff  <= DLL_ST_COUNT;
                        cnt_ff <= load - 24'h000001;
                    end
                end
                DLL_ST_COUNT: begin
                    if (cnt_ff == 24'h000000)
                        st_ff <= DLL_ST_DONE;
                    else
                        cnt_ff <= cnt_ff - 24'h000001;
                end
                DLL_ST_DONE: st_ff <= DLL_ST_DONE;
                default:     st_ff <= DLL_ST_IDLE;
            endcase
        end
    end

    assign busy = (st_ff == DLL_ST_COUNT);
    assign done = (st_ff == DLL_ST_DONE);
endmodule : dll_offhook_timer
`default_nettype wire

// ---- verification/dll_daa_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module dll_daa_regs_props
    import dll_pkg::*;
#(
    parameter int LVS_W = 8
) (
    input wire logic             mclk,
    input wire logic             nrst,
    input wire logic [3:0]       avs_address,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic [31:0]      avs_writedata,
    input wire logic [3:0]       avs_byteenable,
    input wire logic             avs_waitrequest,
    input wire logic             ctrl_line_valid,
    input wire logic [1:0]       ctrl_line_state,
    input wire logic             line_zero_in,
    input wire logic [1:0]       line_state_select,
    input wire logic             device_powerdown,
    input wire logic             line_side_powerdown,
    input wire logic             hybrid_tx_connect,
    input wire logic [1:0]       analog_out_rx_gain,
    input wire logic [1:0]       analog_out_tx_gain,
    input wire logic             analog_rx_mute,
    input wire logic             analog_tx_mute,
    input wire logic [LVS_W-1:0] line_voltage_status
);
    logic wr_ok;
    logic wr_oh;
    logic wr_pp;
    logic wr_gn;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign wr_oh = wr_ok && avs_address == ADDR_OFFHOOK;
    assign wr_pp = wr_ok && avs_address == ADDR_POWER_PATH;
    assign wr_gn = wr_ok && avs_address == ADDR_GAIN;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // bus, line mode, control bits
    // ------------------------------------------------------------
    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("wait state not one cycle");
    property p_lm;
        wr_oh && avs_writedata[1:0] != 2'h3
            |=> line_state_select == $past(avs_writedata[1:0]);
    endproperty
    a_lm: assert property (p_lm)
        else $error("line mode write lost");
    property p_lm_rsvd;
        wr_oh && avs_writedata[1:0] == 2'h3 && !ctrl_line_valid
            |=> $stable(line_state_select);
    endproperty
    a_lm_rsvd: assert property (p_lm_rsvd)
        else $error("reserved line mode taken");
    property p_ctrl;
        ctrl_line_valid && ctrl_line_state != 2'h3 && !avs_write
            |=> line_state_select == $past(ctrl_line_state);
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("controller line mode lost");
    property p_pwr;
        wr_pp |=> device_powerdown == $past(avs_writedata[PDN_BIT])
            && line_side_powerdown == $past(avs_writedata[PDL_BIT]);
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("powerdown bits wrong");
    property p_hbe;
        wr_pp |=> hybrid_tx_connect == $past(avs_writedata[HBE_BIT]);
    endproperty
    a_hbe: assert property (p_hbe)
        else $error("hybrid connect wrong");
    property p_gain;
        wr_gn |=> analog_out_rx_gain == $past(avs_writedata[3:2])
            && analog_out_tx_gain == $past(avs_writedata[1:0]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain fields wrong");
    property p_rx_mute;
        analog_rx_mute == (analog_out_rx_gain == 2'h3);
    endproperty
    a_rx_mute: assert property (p_rx_mute)
        else $error("rx mute wrong");
    property p_tx_mute;
        analog_tx_mute == (analog_out_tx_gain == 2'h3);
    endproperty
    a_tx_mute: assert property (p_tx_mute)
        else $error("tx mute wrong");
    property p_lvs0;
        line_zero_in [*5] |-> line_voltage_status == '0;
    endproperty
    a_lvs0: assert property (p_lvs0)
        else $error("zero volts not zero");
endmodule : dll_daa_regs_props
bind dll_daa_regs dll_daa_regs_props #(.LVS_W(LVS_W)) dll_daa_regs_props_i (
    .mclk(mclk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .ctrl_line_valid(ctrl_line_valid),
    .ctrl_line_state(ctrl_line_state), .line_zero_in(line_zero_in),
    .line_state_select(line_state_select),
    .device_powerdown(device_powerdown),
    .line_side_powerdown(line_side_powerdown),
    .hybrid_tx_connect(hybrid_tx_connect),
    .analog_out_rx_gain(analog_out_rx_gain),
    .analog_out_tx_gain(analog_out_tx_gain),
    .analog_rx_mute(analog_rx_mute), .analog_tx_mute(analog_tx_mute),
    .line_voltage_status(line_voltage_status));
`default_nettype wire

// ---- verification/dll_line_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dll_line_side_model (
    input  wire logic       mclk,
    input  wire logic       lock_req,
    input  wire logic       tone_req,
    input  wire logic [7:0] decivolts,
    input  wire logic       line_side_powerdown,
    output logic            billing_tone_in,
    output logic            frame_lock_in,
    output logic            line_low_in,
    output logic            line_zero_in,
    output logic [7:0]      line_voltage_raw
);
    logic [7:0] noise_ff = 8'h5a;
    always_ff @(posedge mclk) begin
        noise_ff <= noise_ff + 8'h3b;
    end
    // no lock and no tone report in low power
    assign frame_lock_in    = lock_req && !line_side_powerdown;
    assign billing_tone_in  = tone_req && !line_side_powerdown;
    assign line_low_in      = decivolts <= 8'h1e;
    assign line_zero_in     = decivolts == 8'h00;
    // reading is garbage at or below 2 V
    assign line_voltage_raw = decivolts <= 8'h14 ? noise_ff : decivolts;
endmodule : dll_line_side_model
`default_nettype wire

// ---- verification/dll_daa_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dll_daa_regs_tb_top;
    import dll_pkg::*;
    logic        mclk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdq;
    logic        ctrl_line_valid, billing_tone_in, frame_lock_in;
    logic        line_low_in, line_zero_in, offhook_busy, offhook_done;
    logic [1:0]  ctrl_line_state, line_state_select, rx_g, tx_g;
    logic        device_powerdown, line_side_powerdown, hybrid_tx_connect;
    logic        rx_m, tx_m, lock_req, tone_req;
    logic [7:0]  line_voltage_raw, line_voltage_status, volts;
    logic [7:0]  pb[5]  = '{8'h40, 8'h20, 8'h04, 8'h0b, 8'h00};
    logic [7:0]  lvv[4] = '{8'h19, 8'h19, 8'h00, 8'h32};
    logic [7:0]  lvf[4] = '{8'h00, 8'h10, 8'h10, 8'h00};
    logic [7:0]  lve[4] = '{8'h00, 8'h19, 8'h00, 8'h32};
    int          lens[4] = '{40, 20, 10, 2};
    int          fail_count, compares, n;

    dll_daa_regs #(.CYC_512(40), .CYC_128(20), .CYC_64(10), .CYC_8(2))
    dll_daa_regs_i (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_waitrequest(avs_waitrequest), .ctrl_line_valid(ctrl_line_valid),
        .ctrl_line_state(ctrl_line_state), .billing_tone_in(billing_tone_in),
        .frame_lock_in(frame_lock_in), .line_low_in(line_low_in),
        .line_zero_in(line_zero_in), .line_voltage_raw(line_voltage_raw),
        .line_state_select(line_state_select), .offhook_busy(offhook_busy),
        .offhook_done(offhook_done), .device_powerdown(device_powerdown),
        .line_side_powerdown(line_side_powerdown),
        .hybrid_tx_connect(hybrid_tx_connect), .analog_out_rx_gain(rx_g),
        .analog_out_tx_gain(tx_g), .analog_rx_mute(rx_m),
        .analog_tx_mute(tx_m), .line_voltage_status(line_voltage_status));
    dll_line_side_model dll_line_side_model_i (.mclk(mclk),
        .lock_req(lock_req), .tone_req(tone_req), .decivolts(volts),
        .line_side_powerdown(line_side_powerdown),
        .billing_tone_in(billing_tone_in), .frame_lock_in(frame_lock_in),
        .line_low_in(line_low_in), .line_zero_in(line_zero_in),
        .line_voltage_raw(line_voltage_raw));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string w, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= rd;
        avs_write     <= !rd;
        do begin
            @(negedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            end_sim();
        end
        @(posedge mclk);
        rdq = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask : wr
    task automatic rd_chk(input string w, input logic [3:0] a, logic [7:0] e);
        bus(1'b1, a, 8'h00);
        check(w, rdq[7:0], e);
    endtask : rd_chk

    initial begin
        nrst = 1'b0;
        {avs_read, avs_write, ctrl_line_valid, lock_req, tone_req} = '0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        ctrl_line_state = 2'h0;
        volts = 8'h32;
        fail_count = 0;
        compares = 0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd_chk("rst_oh", ADDR_OFFHOOK, 8'h40);
        rd_chk("rst_pp", ADDR_POWER_PATH, 8'h00);
        rd_chk("rst_st", ADDR_LINK_STAT, 8'h00);
        rd_chk("rst_gn", ADDR_GAIN, 8'h0f);
        rd_chk("unmapped", 4'h2, 8'h00);
        check("rst_gain", {2'h0, rx_g, tx_g, rx_m, tx_m}, 8'h3f);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_OFFHOOK, {s[1:0], 6'h00});
            wr(ADDR_OFFHOOK, {s[1:0], 6'h01});
            if (s < 3) check("busy", {7'h0, offhook_busy}, 8'h01);
            n = 0;
            while (offhook_done !== 1'b1 && n < 60) begin
                @(negedge mclk);
                n++;
            end
            if (n >= 60) begin
                fail_count++;
                end_sim();
            end
            check("foh", 8'(n), 8'(lens[s]));
        end
        $display("test offhook length done");
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_OFFHOOK, {6'h00, m[1:0]});
            check("lm", {6'h0, line_state_select}, 8'(m));
        end
        wr(ADDR_OFFHOOK, 8'hff);
        rd_chk("lm_rsvd", ADDR_OFFHOOK, 8'hc2);
        ctrl_line_valid <= 1'b1;
        @(posedge mclk);
        ctrl_line_valid <= 1'b0;
        @(posedge mclk);
        rd_chk("lm_ctrl", ADDR_OFFHOOK, 8'hc0);
        $display("test line mode done");
        foreach (pb[i]) begin
            wr(ADDR_POWER_PATH, pb[i]);
            check("pwr", {5'h0, device_powerdown, line_side_powerdown,
                hybrid_tx_connect}, {5'h0, pb[i][6], pb[i][5], pb[i][2]});
        end
        wr(ADDR_POWER_PATH, 8'h0b);
        bus(1'b1, ADDR_POWER_PATH, 8'h00);
        wr(ADDR_POWER_PATH, rdq[7:0] | 8'h04);
        rd_chk("rmw", ADDR_POWER_PATH, 8'h0f);
        $display("test power path done");
        tone_req <= 1'b1;
        lock_req <= 1'b1;
        wr(ADDR_POWER_PATH, 8'h00);
        repeat (6) @(posedge mclk);
        rd_chk("bt_off", ADDR_LINK_STAT, 8'h08);
        wr(ADDR_POWER_PATH, 8'h80);
        repeat (6) @(posedge mclk);
        rd_chk("bt_on", ADDR_LINK_STAT, 8'h09);
        tone_req <= 1'b0;
        repeat (6) @(posedge mclk);
        rd_chk("bt_hold", ADDR_LINK_STAT, 8'h09);
        rd_chk("bt_clr", ADDR_LINK_STAT, 8'h08);
        wr(ADDR_POWER_PATH, 8'ha0);
        repeat (6) @(posedge mclk);
        rd_chk("lock_lost", ADDR_LINK_STAT, 8'h00);
        wr(ADDR_POWER_PATH, 8'h80);
        repeat (6) @(posedge mclk);
        rd_chk("lock_back", ADDR_LINK_STAT, 8'h08);
        $display("test status done");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_POWER_PATH, lvf[i]);
            volts <= lvv[i];
            repeat (6) @(posedge mclk);
            check("lvs", line_voltage_status, lve[i]);
        end
        for (int g = 0; g < 16; g += 5) begin
            wr(ADDR_GAIN, {4'hf, g[3:0]});
            check("gain", {2'h0, rx_g, tx_g, rx_m, tx_m},
                {2'h0, g[3:0], {2{g == 15}}});
            rd_chk("gain_rd", ADDR_GAIN, {4'h0, g[3:0]});
        end
        avs_byteenable <= 4'h0;
        wr(ADDR_GAIN, 8'h00);
        avs_byteenable <= 4'h1;
        rd_chk("no_lane", ADDR_GAIN, 8'h0f);
        $display("test voltage and gain done");
        end_sim();
    end
endmodule : dll_daa_regs_tb_top
`default_nettype wire
